// ==== hdl/rba_pkg.sv ====
package rba_pkg;
	// Register geometry.
	localparam int REG_WIDTH = 32;
	localparam int WIDTH_EXP = 5;
	localparam int MIN_WIDTH_EXP = 3;
	localparam int ADDR_WIDTH = 4;
	localparam int ARR_ROWS = 2;
	localparam int ARR_COLS = 2;
	// Word addresses of the map.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CTRL_ALIAS = 4'h1;
	localparam logic [3:0] ADDR_EVENT = 4'h2;
	localparam logic [3:0] ADDR_EVENT_ALIAS = 4'h3;
	localparam logic [3:0] ADDR_STATUS_RO = 4'h4;
	localparam logic [3:0] ADDR_CMD_WO = 4'h4;
	localparam logic [3:0] ADDR_EXT = 4'h5;
	localparam logic [3:0] ADDR_EXT_ALIAS = 4'h6;
	localparam logic [3:0] ADDR_ARRAY = 4'h8;
	// Size-only fields of the control register, packed end to end.
	localparam int FLD_A_SIZE = 1;
	localparam int FLD_B_SIZE = 3;
	localparam int FLD_C_SIZE = 8;
	localparam int FLD_A_LO_LSB = 0;
	localparam int FLD_B_LO_LSB = FLD_A_LO_LSB + FLD_A_SIZE;
	localparam int FLD_C_LO_LSB = FLD_B_LO_LSB + FLD_B_SIZE;
	localparam int FLD_A_LO_MSB = REG_WIDTH - FLD_A_SIZE;
	localparam int FLD_B_LO_MSB = FLD_A_LO_MSB - FLD_B_SIZE;
	localparam int FLD_C_LO_MSB = FLD_B_LO_MSB - FLD_C_SIZE;
	localparam int PACKED_BITS = FLD_A_SIZE + FLD_B_SIZE + FLD_C_SIZE;
	// Event register layout.
	localparam int EVENT_BITS = 4;
	// Reset values.
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
	localparam logic [31:0] ARRAY_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ==== hdl/rba_register_bank.sv ====
`timescale 1ns/1ps
module rba_register_bank (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic highBitFirstOrder,
	input wire logic hwPriority,
	input wire logic swRead,
	input wire logic swWrite,
	input wire logic [rba_pkg::ADDR_WIDTH-1:0] swAddr,
	input wire logic [rba_pkg::REG_WIDTH-1:0] swWdata,
	output logic [rba_pkg::REG_WIDTH-1:0] swRdata,
	output logic swRvalid,
	output logic swErr,
	input wire logic [rba_pkg::EVENT_BITS-1:0] hwEventSet,
	input wire logic hwCtrlWe,
	input wire logic [rba_pkg::REG_WIDTH-1:0] hwCtrlData,
	input wire logic [rba_pkg::REG_WIDTH-1:0] hwStatus,
	output logic [rba_pkg::REG_WIDTH-1:0] ctrlValue,
	output logic [rba_pkg::EVENT_BITS-1:0] eventValue,
	output logic [rba_pkg::REG_WIDTH-1:0] cmdValue,
	output logic cmdPulse,
	output logic [rba_pkg::PACKED_BITS-1:0] packedFields,
	output logic extRead,
	output logic extWrite,
	output logic [rba_pkg::REG_WIDTH-1:0] extWdata,
	output logic [rba_pkg::REG_WIDTH-1:0] extWmask,
	input wire logic [rba_pkg::REG_WIDTH-1:0] extRdata
);
	import rba_pkg::*;

	// ************************************************************
	// Elaboration checks on geometry.
	// ************************************************************
	if (REG_WIDTH != (1 << WIDTH_EXP) || WIDTH_EXP < MIN_WIDTH_EXP) begin : gWidthBad
		$error("Register width must be a power of two of at least eight.");
	end
	if (FLD_C_LO_LSB + FLD_C_SIZE > REG_WIDTH || FLD_C_LO_MSB < 0) begin : gFieldBad
		$error("Packed fields exceed the register width.");
	end

	// ************************************************************
	// Decode.
	// ************************************************************
	logic hitCtrl, hitCtrlAlias, hitEvent, hitEventAlias;
	logic hitStatus, hitCmd, hitExt, hitExtAlias, hitArray, hitAny;
	logic [1:0] arrIdx;

	always_comb begin
		hitCtrl = 1'b0;
		hitCtrlAlias = 1'b0;
		hitEvent = 1'b0;
		hitEventAlias = 1'b0;
		hitStatus = 1'b0;
		hitCmd = 1'b0;
		hitExt = 1'b0;
		hitExtAlias = 1'b0;
		hitArray = 1'b0;
		arrIdx = swAddr[1:0];
		if (swAddr == ADDR_CTRL) begin
			hitCtrl = 1'b1;
		end else if (swAddr == ADDR_CTRL_ALIAS) begin
			hitCtrlAlias = 1'b1;
		end else if (swAddr == ADDR_EVENT) begin
			hitEvent = 1'b1;
		end else if (swAddr == ADDR_EVENT_ALIAS) begin
			hitEventAlias = 1'b1;
		end else if (swAddr == ADDR_STATUS_RO) begin
			hitStatus = swRead;
			hitCmd = swWrite;
		end else if (swAddr == ADDR_EXT) begin
			hitExt = 1'b1;
		end else if (swAddr == ADDR_EXT_ALIAS) begin
			hitExtAlias = 1'b1;
		end else if (swAddr[3:2] == ADDR_ARRAY[3:2]) begin
			hitArray = 1'b1;
		end
		hitAny = hitCtrl | hitCtrlAlias | hitEvent | hitEventAlias |
			hitStatus | hitCmd | hitExt | hitExtAlias | hitArray;
	end

	// ************************************************************
	// Internal storage.
	// ************************************************************
	logic [REG_WIDTH-1:0] ctrl_ff, nxt_ctrl;
	logic [EVENT_BITS-1:0] event_ff, nxt_event;
	logic [REG_WIDTH-1:0] cmd_ff, nxt_cmd;
	logic cmdPulse_ff, nxt_cmdPulse;
	logic [REG_WIDTH-1:0] array_ff [ARR_ROWS][ARR_COLS];
	logic [REG_WIDTH-1:0] nxt_array [ARR_ROWS][ARR_COLS];
	logic [REG_WIDTH-1:0] aliasMask;
	logic [EVENT_BITS-1:0] evWr;

	// The control alias exposes only the low half; the rest is kept.
	assign aliasMask = {{(REG_WIDTH/2){1'b0}}, {(REG_WIDTH/2){1'b1}}};

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_event = event_ff;
		nxt_cmd = cmd_ff;
		nxt_cmdPulse = 1'b0;
		evWr = swWdata[EVENT_BITS-1:0];
		// Hardware write to control; software overrides unless hwPriority.
		if (hwCtrlWe && hwPriority) begin
			nxt_ctrl = hwCtrlData;
		end else begin
			if (hwCtrlWe) begin
				nxt_ctrl = hwCtrlData;
			end
			if (swWrite && hitCtrl) begin
				nxt_ctrl = swWdata;
			end else if (swWrite && hitCtrlAlias) begin
				nxt_ctrl = (ctrl_ff & ~aliasMask) | (swWdata & aliasMask);
			end
		end
		if (hwCtrlWe && hwPriority && swWrite && hitCtrlAlias) begin
			nxt_ctrl = hwCtrlData;
		end
		// Event bits: hardware sets, primary clears by one, alias plain rw.
		if (swWrite && hitEvent) begin
			nxt_event = event_ff & ~evWr;
		end else if (swWrite && hitEventAlias) begin
			nxt_event = evWr;
		end
		nxt_event = nxt_event | hwEventSet;
		if (swWrite && hitCmd) begin
			nxt_cmd = swWdata;
			nxt_cmdPulse = 1'b1;
		end
	end

	for (genvar r = 0; r < ARR_ROWS; r++) begin : gRow
		for (genvar c = 0; c < ARR_COLS; c++) begin : gCol
			always_comb begin
				nxt_array[r][c] = array_ff[r][c];
				if (swWrite && hitArray && arrIdx == 2'(r * ARR_COLS + c)) begin
					nxt_array[r][c] = swWdata;
				end
			end
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					array_ff[r][c] <= ARRAY_RESET;
				end else if (clkEn) begin
					array_ff[r][c] <= nxt_array[r][c];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= CTRL_RESET;
			event_ff <= EVENT_RESET[EVENT_BITS-1:0];
			cmd_ff <= ZERO_WORD;
			cmdPulse_ff <= 1'b0;
		end else if (clkEn) begin
			ctrl_ff <= nxt_ctrl;
			event_ff <= nxt_event;
			cmd_ff <= nxt_cmd;
			cmdPulse_ff <= nxt_cmdPulse;
		end
	end

	// ************************************************************
	// External register access port.
	// ************************************************************
	always_comb begin
		extRead = clkEn && swRead && (hitExt || hitExtAlias);
		extWrite = clkEn && swWrite && (hitExt || hitExtAlias);
		extWdata = swWdata;
		extWmask = hitExtAlias ? aliasMask : ~ZERO_WORD;
	end

	// ************************************************************
	// Read path and field packing.
	// ************************************************************
	logic [REG_WIDTH-1:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid, err_ff, nxt_err;
	logic [PACKED_BITS-1:0] nxt_packed, packed_ff;

	always_comb begin
		nxt_rdata = ZERO_WORD;
		nxt_rvalid = swRead;
		nxt_err = (swRead || swWrite) && !hitAny;
		if (swRead) begin
			if (hitCtrl) begin
				nxt_rdata = ctrl_ff;
			end else if (hitCtrlAlias) begin
				nxt_rdata = ctrl_ff & aliasMask;
			end else if (hitEvent || hitEventAlias) begin
				nxt_rdata = {{(REG_WIDTH-EVENT_BITS){1'b0}}, event_ff};
			end else if (hitStatus) begin
				nxt_rdata = hwStatus;
			end else if (hitExt) begin
				nxt_rdata = extRdata;
			end else if (hitExtAlias) begin
				nxt_rdata = extRdata & aliasMask;
			end else if (hitArray) begin
				nxt_rdata = array_ff[arrIdx[1]][arrIdx[0]];
			end
		end
		if (highBitFirstOrder) begin
			nxt_packed = {ctrl_ff[FLD_C_LO_MSB +: FLD_C_SIZE],
				ctrl_ff[FLD_B_LO_MSB +: FLD_B_SIZE],
				ctrl_ff[FLD_A_LO_MSB +: FLD_A_SIZE]};
		end else begin
			nxt_packed = {ctrl_ff[FLD_C_LO_LSB +: FLD_C_SIZE],
				ctrl_ff[FLD_B_LO_LSB +: FLD_B_SIZE],
				ctrl_ff[FLD_A_LO_LSB +: FLD_A_SIZE]};
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= ZERO_WORD;
			rvalid_ff <= 1'b0;
			err_ff <= 1'b0;
			packed_ff <= '0;
		end else if (clkEn) begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			err_ff <= nxt_err;
			packed_ff <= nxt_packed;
		end
	end

	assign swRdata = rdata_ff;
	assign swRvalid = rvalid_ff;
	assign swErr = err_ff;
	assign ctrlValue = ctrl_ff;
	assign eventValue = event_ff;
	assign cmdValue = cmd_ff;
	assign cmdPulse = cmdPulse_ff;
	assign packedFields = packed_ff;

	// ************************************************************
	// Checks.
	// ************************************************************
	property p_sw_full_write;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swWrite && hitCtrl && !(hwCtrlWe && hwPriority)
		|=> ctrlValue == $past(swWdata);
	endproperty
	a_sw_full_write: assert property (p_sw_full_write) else $error("Control write lost.");

	property p_alias_keeps_hidden;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swWrite && hitCtrlAlias && !hwCtrlWe
		|=> ctrlValue[31:16] == $past(ctrlValue[31:16]) &&
			ctrlValue[15:0] == $past(swWdata[15:0]);
	endproperty
	a_alias_keeps_hidden: assert property (p_alias_keeps_hidden) else $error("Alias write wrong.");

	property p_alias_read_seen;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swRead && hitCtrlAlias
		|=> swRdata == ($past(ctrlValue) & 32'h0000_ffff);
	endproperty
	a_alias_read_seen: assert property (p_alias_read_seen) else $error("Alias read differs.");

	property p_woclr;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swWrite && hitEvent && hwEventSet == '0
		|=> eventValue == ($past(eventValue) & ~$past(swWdata[3:0]));
	endproperty
	a_woclr: assert property (p_woclr) else $error("Write-one-clear wrong.");

	property p_alias_plain;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swWrite && hitEventAlias && hwEventSet == '0
		|=> eventValue == $past(swWdata[3:0]);
	endproperty
	a_alias_plain: assert property (p_alias_plain) else $error("Alias event write wrong.");

	property p_hw_priority;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && hwCtrlWe && hwPriority |=> ctrlValue == $past(hwCtrlData);
	endproperty
	a_hw_priority: assert property (p_hw_priority) else $error("Hardware lost priority.");

	property p_ext_no_store;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swWrite && hitExt |-> extWrite && extWmask == 32'hffff_ffff;
	endproperty
	a_ext_no_store: assert property (p_ext_no_store) else $error("External write lost.");

	property p_cmd_shared;
		@(posedge mclk) disable iff (!reset_n)
		clkEn && swWrite && swAddr == ADDR_CMD_WO
		|=> cmdPulse && cmdValue == $past(swWdata);
	endproperty
	a_cmd_shared: assert property (p_cmd_shared) else $error("Command write lost.");
endmodule

// ==== verification/rba_register_bank_tb_top.sv ====
`timescale 1ns/1ps
module rba_register_bank_tb_top;
	import rba_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic highBitFirstOrder = 1'b0;
	logic hwPriority = 1'b0;
	logic swRead = 1'b0;
	logic swWrite = 1'b0;
	logic [ADDR_WIDTH-1:0] swAddr = 4'h0;
	logic [REG_WIDTH-1:0] swWdata = 32'h0;
	logic [REG_WIDTH-1:0] swRdata;
	logic swRvalid;
	logic swErr;
	logic [EVENT_BITS-1:0] hwEventSet = 4'h0;
	logic hwCtrlWe = 1'b0;
	logic [REG_WIDTH-1:0] hwCtrlData = 32'h0;
	logic [REG_WIDTH-1:0] hwStatus = 32'h5a3c_9611;
	logic [REG_WIDTH-1:0] extRdata = 32'hc3e1_7f02;
	logic [REG_WIDTH-1:0] ctrlValue, cmdValue, extWdata, extWmask;
	logic [EVENT_BITS-1:0] eventValue;
	logic [PACKED_BITS-1:0] packedFields;
	logic cmdPulse, extRead, extWrite;
	int bad_count = 0;
	int checked = 0;
	int seed = 32'hb79b;
	logic [31:0] ctrlExp, r, m;
	logic [31:0] gotRdata;
	logic gotRvalid, gotErr, gotPulse;
	logic [31:0] arr [4];
	logic [3:0] unm [5] = '{4'h7, 4'hc, 4'hd, 4'he, 4'hf};

	rba_register_bank i_dut (
		.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
		.highBitFirstOrder(highBitFirstOrder), .hwPriority(hwPriority),
		.swRead(swRead), .swWrite(swWrite), .swAddr(swAddr),
		.swWdata(swWdata), .swRdata(swRdata), .swRvalid(swRvalid),
		.swErr(swErr), .hwEventSet(hwEventSet), .hwCtrlWe(hwCtrlWe),
		.hwCtrlData(hwCtrlData), .hwStatus(hwStatus),
		.ctrlValue(ctrlValue), .eventValue(eventValue),
		.cmdValue(cmdValue), .cmdPulse(cmdPulse),
		.packedFields(packedFields), .extRead(extRead),
		.extWrite(extWrite), .extWdata(extWdata), .extWmask(extWmask),
		.extRdata(extRdata)
	);

	always #2.5 mclk = ~mclk;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [11:0] packExp(input logic [31:0] c,
			input logic hi);
		if (hi) begin
			return {c[27:20], c[30:28], c[31]};
		end
		return c[11:0];
	endfunction

	task automatic chk(input string what, input logic [31:0] e,
			input logic [31:0] got);
		checked++;
		if (got !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, got);
		end
	endtask

	// Called at a falling edge. The one-cycle answers are kept while they
	// stand, then a quiet cycle follows so no strobe is lowered and raised
	// again in the same time step.
	task automatic acc(input logic wr, input logic [3:0] a,
			input logic [31:0] d);
		swWrite = wr;
		swRead = !wr;
		swAddr = a;
		swWdata = d;
		@(negedge mclk);
		gotRdata = swRdata;
		gotRvalid = swRvalid;
		gotErr = swErr;
		gotPulse = cmdPulse;
		swWrite = 1'b0;
		swRead = 1'b0;
		hwCtrlWe = 1'b0;
		hwEventSet = 4'h0;
		@(negedge mclk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk("swRvalid", 32'h1, 32'(gotRvalid));
		chk("swErr", 32'h0, 32'(gotErr));
		chk("swRdata", e, gotRdata);
	endtask

	task automatic give_verdict;
		$display("Checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#10000;
		bad_count++;
		give_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		chk("ctrlValue", CTRL_RESET, ctrlValue);
		chk("eventValue", EVENT_RESET, 32'(eventValue));
		for (int i = 0; i < 4; i++) begin
			ctrlExp = $random(seed);
			highBitFirstOrder = i[0];
			acc(1'b1, ADDR_CTRL, ctrlExp);
			chk("ctrlValue", ctrlExp, ctrlValue);
			rd(ADDR_CTRL, ctrlExp);
			chk("packed", 32'(packExp(ctrlExp, i[0])), 32'(packedFields));
			rd(ADDR_CTRL_ALIAS, ctrlExp & 32'h0000ffff);
			r = $random(seed);
			acc(1'b1, ADDR_CTRL_ALIAS, r);
			ctrlExp = {ctrlExp[31:16], r[15:0]};
			rd(ADDR_CTRL, ctrlExp);
		end
		for (int p = 0; p < 2; p++) begin
			hwPriority = p[0];
			hwCtrlData = $random(seed);
			r = $random(seed);
			hwCtrlWe = 1'b1;
			acc(1'b1, ADDR_CTRL, r);
			chk("collision", p[0] ? hwCtrlData : r, ctrlValue);
		end
		ctrlExp = $random(seed);
		hwCtrlData = ctrlExp;
		hwCtrlWe = 1'b1;
		@(negedge mclk);
		hwCtrlWe = 1'b0;
		rd(ADDR_CTRL_ALIAS, ctrlExp & 32'h0000ffff);
		rd(ADDR_CTRL, ctrlExp);
		hwEventSet = 4'h5;
		@(negedge mclk);
		hwEventSet = 4'h0;
		chk("event set", 32'h5, 32'(eventValue));
		acc(1'b1, ADDR_EVENT, 32'h1);
		chk("event w1c", 32'h4, 32'(eventValue));
		acc(1'b1, ADDR_EVENT_ALIAS, 32'ha);
		chk("event plain", 32'ha, 32'(eventValue));
		rd(ADDR_EVENT, 32'ha);
		hwEventSet = 4'h2;
		acc(1'b1, ADDR_EVENT, 32'hf);
		chk("event race", 32'h2, 32'(eventValue));
		hwStatus = $random(seed);
		rd(ADDR_STATUS_RO, hwStatus);
		r = $random(seed);
		acc(1'b1, ADDR_CMD_WO, r);
		chk("cmdValue", r, cmdValue);
		chk("cmdPulse", 32'h1, 32'(gotPulse));
		chk("cmdPulse end", 32'h0, 32'(cmdPulse));
		for (int k = 0; k < 2; k++) begin
			m = k ? 32'h0000ffff : 32'hffffffff;
			r = $random(seed);
			extRdata = $random(seed);
			fork
				acc(1'b1, k ? ADDR_EXT_ALIAS : ADDR_EXT, r);
				begin
					#1;
					chk("extWrite", 32'h1, 32'(extWrite));
					chk("extWdata", r, extWdata);
					chk("extWmask", m, extWmask);
				end
			join
			fork
				rd(k ? ADDR_EXT_ALIAS : ADDR_EXT, extRdata & m);
				#1 chk("extRead", 32'h1, 32'(extRead));
			join
		end
		for (int i = 0; i < 4; i++) begin
			arr[i] = $random(seed);
			acc(1'b1, ADDR_ARRAY + 4'(i), arr[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_ARRAY + 4'(i), arr[i]);
		end
		foreach (unm[i]) begin
			acc(1'b1, unm[i], 32'hffffffff);
			chk("swErr", 32'h1, 32'(gotErr));
		end
		chk("ctrl kept", ctrlExp, ctrlValue);
		clkEn = 1'b0;
		acc(1'b1, ADDR_CTRL, ~ctrlExp);
		clkEn = 1'b1;
		chk("frozen", ctrlExp, ctrlValue);
		give_verdict();
	end
endmodule
